// >>> pkg/sss_pkg.sv
// Register map, field layout and carrier types of the sync source bank.
package sss_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0]  IDX_MIX_OSC_FMT  = 8'h1f;
  localparam logic [7:0]  IDX_FIFO_DIVIDER = 8'h20;
  localparam logic [7:0]  IDX_RSVD_A       = 8'h21;
  localparam logic [7:0]  IDX_RSVD_B       = 8'h22;

  // Reset values.
  localparam logic [15:0] RST_MIX_OSC_FMT  = 16'h1140;
  localparam logic [15:0] RST_FIFO_DIVIDER = 16'h2400;
  localparam logic [15:0] RST_RSVD_A       = 16'h0000;
  localparam logic [15:0] RST_RSVD_B       = 16'h1b1b;

  // Field positions in the mixer/oscillator/formatter register.
  localparam int unsigned MIX_SEL_LSB      = 12;
  localparam int unsigned NCO_SEL_LSB      = 4;
  localparam int unsigned FMT_SEL_LSB      = 2;
  localparam int unsigned SW_SYNC_BIT      = 1;

  // Field positions in the FIFO/divider register.
  localparam int unsigned FIN_SEL_LSB      = 12;
  localparam int unsigned FOUT_SEL_LSB     = 8;
  localparam int unsigned CLKDIV_SEL_BIT   = 0;

  // Formatter source codes.
  localparam logic [1:0]  FMT_SRC_FRAME    = 2'h0;
  localparam logic [1:0]  FMT_SRC_EXT      = 2'h1;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  // Pins from the data source, asynchronous to the device clock.
  typedef struct packed {
    logic frame;
    logic ext_sync;
    logic output_strobe_pin;
  } sss_pins_t;

  // Sync requests toward the datapath blocks, one bit per block.
  typedef struct packed {
    logic mixer;
    logic osc_acc;
    logic formatter;
    logic fifo_in;
    logic fifo_out;
    logic clkdiv;
  } sss_sync_t;

endpackage

// >>> logic/sss_sync_in.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/10ps
module sss_sync_in #(
  parameter int unsigned W = 3
) (
  input  wire logic         i_ref_clk, // Device clock.
  input  wire logic         i_rst,     // Synchronous reset, active high.
  input  wire logic [W-1:0] i_async,   // Pin levels from outside.
  output logic      [W-1:0] o_level    // Levels safe for local logic.
);

  logic [W-1:0] meta_q;
  logic [W-1:0] level_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      meta_q  <= '0;
      level_q <= '0;
    end
    else
    begin
      meta_q  <= i_async;
      level_q <= meta_q;
    end
  end

  assign o_level = level_q;

endmodule

// >>> logic/sss_top.sv
// Sync source select register bank with an AXI4-Lite slave port.
//
// Notes on behaviour
// - The mixer mask in bits 15:12 enables software, pin, strobe, write.
// - The accumulator mask in bits 7:4 enables software, pin, strobe, frame.
// - All enabled sources of a mask are ORed into one sync request.
// - The formatter takes frame on 00, the sync pin on 01, none otherwise.
// - Bit 1 is a software sync level held until software writes it to 0.
// - The FIFO input mask in bits 15:12 of the second register resets 0010.
// - The FIFO output mask in bits 11:8 enables software, strobe, pin, frame.
// - Divider bit 0 picks the strobe, or frame/pin/software via FIFO input.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module sss_top (
  input  wire logic              i_ref_clk,        // Device clock.
  input  wire logic              i_rst,            // Sync reset, high.
  input  wire logic [7:0]        i_s_axi_awaddr,   // Write address.
  input  wire logic              i_s_axi_awvalid,  // Write address valid.
  output logic                   o_s_axi_awready,  // Write address ready.
  input  wire logic [31:0]       i_s_axi_wdata,    // Write data.
  input  wire logic [3:0]        i_s_axi_wstrb,    // Write byte enables.
  input  wire logic              i_s_axi_wvalid,   // Write data valid.
  output logic                   o_s_axi_wready,   // Write data ready.
  output logic [1:0]             o_s_axi_bresp,    // Write response.
  output logic                   o_s_axi_bvalid,   // Write response valid.
  input  wire logic              i_s_axi_bready,   // Write response ready.
  input  wire logic [7:0]        i_s_axi_araddr,   // Read address.
  input  wire logic              i_s_axi_arvalid,  // Read address valid.
  output logic                   o_s_axi_arready,  // Read address ready.
  output logic [31:0]            o_s_axi_rdata,    // Read data.
  output logic [1:0]             o_s_axi_rresp,    // Read response.
  output logic                   o_s_axi_rvalid,   // Read data valid.
  input  wire logic              i_s_axi_rready,   // Read data ready.
  input  wire sss_pkg::sss_pins_t i_pins,          // Frame, sync, strobe.
  output sss_pkg::sss_sync_t     o_sync            // Sync per block.
);

  import sss_pkg::*;

  // Register storage.
  logic [15:0] mix_q;
  logic [15:0] fifo_q;
  logic [15:0] rsva_q;
  logic [15:0] rsvb_q;

  // Write channel holding state.
  logic        aw_q;
  logic [7:0]  awaddr_q;
  logic        w_q;
  logic [15:0] wdata_q;
  logic [1:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  // Read channel state.
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Sync state.
  logic        auto_q;
  sss_sync_t   sync_q;
  sss_sync_t   sync_d;

  // Pin synchronisation. The three pins come from the data source and
  // are not related to the device clock, so every level passes two
  // flops before the selection logic sees it. Users must allow for the
  // two cycles of latency that this adds to every pin-driven sync.
  logic [2:0]  pin_lvl;
  logic        frame_s;
  logic        ext_s;
  logic        strobe_s;

  sss_sync_in #(
    .W (3)
  ) i_sss_sync_in (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_pins.frame, i_pins.ext_sync, i_pins.output_strobe_pin}),
    .o_level   (pin_lvl)
  );

  // Bit order of the synchroniser follows the concatenation above.
  assign frame_s  = pin_lvl[2];
  assign ext_s    = pin_lvl[1];
  assign strobe_s = pin_lvl[0];

  // Write path: address and data are taken in either order and the
  // register update happens once both are held. A channel that has
  // been taken drops its ready until the response has been accepted,
  // so a fast master cannot queue a second write behind the first.
  wire         aw_take  = i_s_axi_awvalid && o_s_axi_awready;
  wire         w_take   = i_s_axi_wvalid && o_s_axi_wready;
  // The write fires once both halves are held and no answer is pending.
  wire         do_write = aw_q && w_q && !bvalid_q;
  wire  [7:0]  wr_idx   = {2'h0, awaddr_q[7:2]};
  wire         wr_algn  = (awaddr_q[1:0] == 2'h0);
  wire         wr_mix   = wr_algn && (wr_idx == IDX_MIX_OSC_FMT);
  wire         wr_fifo  = wr_algn && (wr_idx == IDX_FIFO_DIVIDER);
  wire         wr_rsva  = wr_algn && (wr_idx == IDX_RSVD_A);
  wire         wr_rsvb  = wr_algn && (wr_idx == IDX_RSVD_B);
  wire         wr_hit   = wr_mix || wr_fifo || wr_rsva || wr_rsvb;
  // Lane 0 writes bits 7:0 and lane 1 writes bits 15:8.
  wire  [15:0] wr_mask  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Readies are combinational, so a channel can be taken in the cycle
  // in which its valid rises.
  assign o_s_axi_awready = !aw_q && !bvalid_q;
  assign o_s_axi_wready  = !w_q && !bvalid_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;

  // Each channel has its own holding flag, so either may arrive first.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      aw_q <= 1'b0;
    else if (aw_take)
      aw_q <= 1'b1;
    else if (do_write)
      aw_q <= 1'b0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      awaddr_q <= 8'h00;
    else if (aw_take)
      awaddr_q <= i_s_axi_awaddr;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      w_q <= 1'b0;
    else if (w_take)
      w_q <= 1'b1;
    else if (do_write)
      w_q <= 1'b0;
  end

  // Only the two low byte lanes are kept: every register is 16 bits
  // wide, and the upper lanes of a write are dropped.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end
    else if (w_take)
    begin
      wdata_q <= i_s_axi_wdata[15:0];
      wstrb_q <= i_s_axi_wstrb[1:0];
    end
  end

  // The response stands until the master raises bready.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      bvalid_q <= 1'b0;
    else if (do_write)
      bvalid_q <= 1'b1;
    else if (i_s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // A miss is still answered, with a decode error, so a stray address
  // never hangs the master.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      bresp_q <= RESP_OKAY;
    else if (do_write)
      bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
  end

  // Byte-lane merge of a write into a stored word.
  // Lanes with a clear strobe keep their old value.
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Per-register write enables.
  wire         wen_mix  = do_write && wr_mix;
  wire         wen_fifo = do_write && wr_fifo;
  wire         wen_rsva = do_write && wr_rsva;
  wire         wen_rsvb = do_write && wr_rsvb;

  // The software sync bit is stored like any field; its level stays
  // asserted until a later write clears it. Software owns the clear,
  // so a forgotten write leaves the blocks held in sync.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      mix_q <= RST_MIX_OSC_FMT;
    else if (wen_mix)
      mix_q <= merge(mix_q, wdata_q, wr_mask);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      fifo_q <= RST_FIFO_DIVIDER;
    else if (wen_fifo)
      fifo_q <= merge(fifo_q, wdata_q, wr_mask);
  end

  // Reserved words are kept writable so they read back what was set;
  // the bank relies on software to leave them alone.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      rsva_q <= RST_RSVD_A;
    else if (wen_rsva)
      rsva_q <= merge(rsva_q, wdata_q, wr_mask);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      rsvb_q <= RST_RSVD_B;
    else if (wen_rsvb)
      rsvb_q <= merge(rsvb_q, wdata_q, wr_mask);
  end

  // Read path. The address is decoded straight from the bus in the
  // cycle in which it is taken, so the answer is ready one edge later
  // with no wait state.
  wire         ar_take  = i_s_axi_arvalid && o_s_axi_arready;
  wire  [7:0]  rd_idx   = {2'h0, i_s_axi_araddr[7:2]};
  wire         rd_algn  = (i_s_axi_araddr[1:0] == 2'h0);
  wire         rd_mix   = rd_algn && (rd_idx == IDX_MIX_OSC_FMT);
  wire         rd_fifo  = rd_algn && (rd_idx == IDX_FIFO_DIVIDER);
  wire         rd_rsva  = rd_algn && (rd_idx == IDX_RSVD_A);
  wire         rd_rsvb  = rd_algn && (rd_idx == IDX_RSVD_B);
  wire         rd_hit   = rd_mix || rd_fifo || rd_rsva || rd_rsvb;
  // Misses read as zero, and the upper half of the bus is always zero.
  wire  [15:0] rd_word  = ({16{rd_mix}}  & mix_q)
                        | ({16{rd_fifo}} & fifo_q)
                        | ({16{rd_rsva}} & rsva_q)
                        | ({16{rd_rsvb}} & rsvb_q);

  // One read at a time: the address channel closes while data waits.
  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      rvalid_q <= 1'b0;
    else if (ar_take)
      rvalid_q <= 1'b1;
    else if (i_s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Data and response are only loaded on a take, so they stand
  // unchanged for as long as the master keeps the answer waiting.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  // Sync source selection. Each mask is ANDed with its own source
  // vector, whose bit order follows the mask field, so a disabled
  // source is ignored even while its pin toggles.
  // Field views of the two live registers.
  wire  [3:0]  mix_sel  = mix_q[MIX_SEL_LSB +: 4];
  wire  [3:0]  nco_sel  = mix_q[NCO_SEL_LSB +: 4];
  wire  [1:0]  fmt_sel  = mix_q[FMT_SEL_LSB +: 2];
  wire         sw_sync  = mix_q[SW_SYNC_BIT];
  wire  [3:0]  fin_sel  = fifo_q[FIN_SEL_LSB +: 4];
  wire  [3:0]  fout_sel = fifo_q[FOUT_SEL_LSB +: 4];
  wire         div_sel  = fifo_q[CLKDIV_SEL_BIT];

  // Any accepted write to a mapped register is one auto-sync event,
  // seen a cycle later so the new values are already stored. Reserved
  // words count as well, since a write there may be a deliberate kick.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      auto_q <= 1'b0;
    else
      auto_q <= do_write && wr_hit;
  end

  // Source vectors in mask bit order, most significant first.
  wire  [3:0]  mix_src  = {sw_sync, ext_s, strobe_s, auto_q};
  wire  [3:0]  nco_src  = {sw_sync, ext_s, strobe_s, frame_s};
  wire  [3:0]  fin_src  = {sw_sync, ext_s, strobe_s, frame_s};
  wire  [3:0]  fout_src = {sw_sync, strobe_s, ext_s, frame_s};
  // The strobe is masked out so the divider never takes it on this path.
  // Bit 13 of the input mask therefore has no effect on the divider.
  wire  [3:0]  div_src  = {sw_sync, ext_s, 1'b0, frame_s};

  // The formatter takes one source only, so it is a select, not a mask.
  wire         fmt_hit  = (fmt_sel == FMT_SRC_FRAME) ? frame_s :
                          (fmt_sel == FMT_SRC_EXT)   ? ext_s   :
                          1'b0;

  always_comb
  begin
    sync_d           = '0;
    sync_d.mixer     = |(mix_sel & mix_src);
    sync_d.osc_acc   = |(nco_sel & nco_src);
    sync_d.formatter = fmt_hit;
    sync_d.fifo_in   = |(fin_sel & fin_src);
    sync_d.fifo_out  = |(fout_sel & fout_src);
    sync_d.clkdiv    = div_sel ? |(fin_sel & div_src) : strobe_s;
  end

  // One register stage between the sources and the outputs keeps the
  // requests free of decode glitches while still acting within the
  // single cycle that the datapath allows.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      sync_q <= '0;
    else
      sync_q <= sync_d;
  end

  assign o_sync = sync_q;

endmodule

// >>> test/sss_src_model.sv
// Data source model: drives frame, sync and strobe pins off the clock.
`timescale 1ns/10ps
module sss_src_model
  import sss_pkg::*;
(
  input  wire logic       i_ref_clk, // Device clock.
  input  wire logic [2:0] i_cmd,     // Wanted frame, sync, strobe.
  output sss_pins_t       o_pins     // Pin levels.
);
  initial o_pins = '0;
  // The skew keeps pin edges away from the sampling edge, as a real source.
  always @(posedge i_ref_clk)
    o_pins <= #3 i_cmd;
endmodule

// >>> test/sss_top_sva.sv
// Checker for bus handshakes and sync outputs of the bank.
`timescale 1ns/10ps
module sss_top_sva
  import sss_pkg::*;
(
  input wire logic        i_ref_clk,       // Clock.
  input wire logic        i_rst,           // Reset.
  input wire logic        o_s_axi_awready, // Aw ready.
  input wire logic        o_s_axi_wready,  // W ready.
  input wire logic [1:0]  o_s_axi_bresp,   // B resp.
  input wire logic        o_s_axi_bvalid,  // B valid.
  input wire logic        i_s_axi_bready,  // B ready.
  input wire logic        i_s_axi_arvalid, // Ar valid.
  input wire logic        o_s_axi_arready, // Ar ready.
  input wire logic [31:0] o_s_axi_rdata,   // R data.
  input wire logic [1:0]  o_s_axi_rresp,   // R resp.
  input wire logic        o_s_axi_rvalid,  // R valid.
  input wire logic        i_s_axi_rready,  // R ready.
  input wire sss_pins_t   i_pins,          // Pins.
  input wire sss_sync_t   o_sync           // Sync out.
);
  wire fe = i_pins.frame | i_pins.ext_sync;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  sequence s_b_wait;
    o_s_axi_bvalid && !i_s_axi_bready;
  endsequence
  a_b_hold: assert property (s_b_wait |=> o_s_axi_bvalid
    && $stable(o_s_axi_bresp)) else $error("bresp dropped early");
  a_r_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata moved");
  a_busy_refuse: assert property (o_s_axi_bvalid
    |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write not refused");
  a_rd_refuse: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read not refused");
  a_ar_answer: assert property (s_rd_take |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_b_start: assert property ($rose(o_s_axi_bvalid)
    |-> !$past(o_s_axi_awready) && !$past(o_s_axi_wready))
    else $error("early b");
  a_rd_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 0)
    else $error("rdata upper bits set");
  a_fmt_cause: assert property (o_sync.formatter
    |-> $past(fe, 2) || $past(fe, 3) || $past(fe, 4)) else $error("fmt sync");
  a_rst_quiet: assert property (disable iff (1'b0)
    $past(i_rst) |-> o_sync == '0) else $error("sync during reset");
endmodule
bind sss_top sss_top_sva i_sss_top_sva(.i_ref_clk, .i_rst, .o_s_axi_awready,
  .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
  .o_s_axi_rvalid, .i_s_axi_rready, .i_pins, .o_sync);

// >>> test/sync_source_select_bench.sv
// Self-checking bench for the sync source select bank.
`timescale 1ns/10ps
module sync_source_select_bench;
  import sss_pkg::*;
  logic        ref_clk = 0, rst = 1;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [2:0]  pin_cmd = 0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  sss_pins_t   pins;
  sss_sync_t   sync;
  int          failures = 0, cmp_count = 0;
  sss_top i_sss_top(.i_ref_clk(ref_clk), .i_rst(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_pins(pins),
    .o_sync(sync));
  sss_src_model i_sss_src_model(.i_ref_clk(ref_clk), .i_cmd(pin_cmd),
    .o_pins(pins));
  initial forever #5 ref_clk = ~ref_clk;
  task finish_test;
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task wait_out(input int n);
    if (n >= 50)
    begin
      failures++;
      finish_test;
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 0;
    wait_out(n);
    chk("bresp", {30'h0, r}, {30'h0, bresp});
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 0;
    wait_out(n);
    chk("rdata", d, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask
  // Settles past the three-flop pin path before sampling the outputs.
  task apply(input logic [15:0] r1, r2, input logic [2:0] p,
             input logic [5:0] e);
    axi_wr(8'h7c, {16'h0, r1}, RESP_OKAY);
    axi_wr(8'h80, {16'h0, r2}, RESP_OKAY);
    @(posedge ref_clk);
    pin_cmd <= p;
    repeat (6) @(posedge ref_clk);
    chk("o_sync", {26'h0, e}, {26'h0, sync});
    axi_rd(8'h7c, {16'h0, r1}, RESP_OKAY);
  endtask
  task t_reset;
    chk("o_sync", 32'h0, {26'h0, sync});
    axi_rd(8'h7c, 32'h1140, RESP_OKAY);
    axi_rd(8'h80, 32'h2400, RESP_OKAY);
    axi_rd(8'h84, 32'h0, RESP_OKAY);
    axi_rd(8'h88, 32'h1b1b, RESP_OKAY);
    axi_rd(8'h8c, 32'h0, RESP_DECERR);
  endtask
  task t_auto;
    int k;
    k = 0;
    axi_wr(8'h7c, 32'h100c, RESP_OKAY);
    repeat (8)
    begin
      @(posedge ref_clk);
      k += sync.mixer;
    end
    chk("auto", 32'h1, k);
  endtask
  task t_mixer;
    apply(16'h600c, 16'h0, 3'b010, 6'b100000);
    apply(16'h600c, 16'h0, 3'b001, 6'b100001);
    apply(16'h600c, 16'h0, 3'b100, 6'b000000);
  endtask
  task t_osc;
    apply(16'h00fc, 16'h0, 3'b100, 6'b010000);
    apply(16'h00fc, 16'h0, 3'b001, 6'b010001);
    apply(16'h002c, 16'h0, 3'b100, 6'b000000);
  endtask
  task t_fmt;
    apply(16'h0000, 16'h0, 3'b100, 6'b001000);
    apply(16'h0000, 16'h0, 3'b010, 6'b000000);
    apply(16'h0004, 16'h0, 3'b010, 6'b001000);
    apply(16'h0004, 16'h0, 3'b100, 6'b000000);
    apply(16'h0008, 16'h0, 3'b110, 6'b000000);
    apply(16'h000c, 16'h0, 3'b110, 6'b000000);
  endtask
  task t_soft;
    apply(16'h808e, 16'h8801, 3'b000, 6'b110111);
    apply(16'h808c, 16'h8801, 3'b000, 6'b000000);
  endtask
  task t_fifo;
    apply(16'h000c, 16'h0400, 3'b001, 6'b000011);
    apply(16'h000c, 16'h1001, 3'b100, 6'b000101);
    apply(16'h000c, 16'h1001, 3'b001, 6'b000000);
    apply(16'h000c, 16'h2000, 3'b001, 6'b000101);
  endtask
  task t_bus;
    axi_wr(8'h7c, 32'hffff000c, RESP_OKAY);
    axi_rd(8'h7c, 32'h000c, RESP_OKAY);
    axi_wr(8'h8c, 32'h1234, RESP_DECERR);
    axi_wr(8'h84, 32'h0, RESP_OKAY);
    axi_rd(8'h88, 32'h1b1b, RESP_OKAY);
    wstrb <= 4'h2;
    axi_wr(8'h7c, 32'h0000_ff30, RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(8'h7c, 32'h0000_ff0c, RESP_OKAY);
    axi_rd(8'h7d, 32'h0, RESP_DECERR);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    t_reset;
    t_auto;
    t_mixer;
    t_osc;
    t_fmt;
    t_soft;
    t_fifo;
    t_bus;
    finish_test;
  end
endmodule
